// file: shared/ffp_pkg.sv
// Constants, codes and state type for the parallel flash programming port
package ffp_pkg;

  // Bus and array geometry
  localparam int DATA_W = 16;
  localparam int MODE_W = 4;
  localparam int ADDR_W = 32;
  localparam int FLASH_AW = 15;
  localparam int PAGE_AW = 6;
  localparam int PAGE_WORDS = 64;
  localparam int PAGE_NUM_W = FLASH_AW - PAGE_AW;
  localparam int REGION_W = 4;
  localparam int LOCK_N = 16;
  localparam int FUSE_N = 3;

  // Mode field codes
  localparam logic [3:0] MODE_CMD = 4'h0;
  localparam logic [3:0] MODE_ADDR_FIRST = 4'h1;
  localparam logic [3:0] MODE_ADDR_SECOND = 4'h2;
  localparam logic [3:0] MODE_ADDR_THIRD = 4'h3;
  localparam logic [3:0] MODE_ADDR_LAST = 4'h4;
  localparam logic [3:0] MODE_DATA = 4'h5;

  // Command words
  localparam logic [15:0] CMD_NONE = 16'h0000;
  localparam logic [15:0] CMD_READ = 16'h0011;
  localparam logic [15:0] CMD_PAGE_WRITE = 16'h0012;
  localparam logic [15:0] CMD_PAGE_WRITE_LOCK = 16'h0022;
  localparam logic [15:0] CMD_ERASE_THEN_WRITE = 16'h0032;
  localparam logic [15:0] CMD_ERASE_WRITE_LOCK = 16'h0042;
  localparam logic [15:0] CMD_FULL_ERASE = 16'h0013;
  localparam logic [15:0] CMD_SET_REGION_LOCK = 16'h0014;
  localparam logic [15:0] CMD_CLEAR_REGION_LOCK = 16'h0024;
  localparam logic [15:0] CMD_GET_REGION_LOCK = 16'h0015;
  localparam logic [15:0] CMD_SET_FUSE = 16'h0034;
  localparam logic [15:0] CMD_CLEAR_FUSE = 16'h0044;
  localparam logic [15:0] CMD_GET_FUSE = 16'h0025;
  localparam logic [15:0] CMD_SET_SECURITY = 16'h0054;
  localparam logic [15:0] CMD_GET_SECURITY = 16'h0035;
  localparam logic [15:0] CMD_GET_VERSION = 16'h001E;

  // Fixed words and reset values
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD = 16'h0000;
  localparam logic [15:0] VERSION_WORD = 16'h0001; // Arbitrary value
  localparam logic [31:0] ADDR_RST = 32'h0000_0000;
  localparam logic [15:0] LOCK_RST = 16'h0000;
  localparam logic [2:0] FUSE_RST = 3'h0;

  // Handshake sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_EXEC,
    ST_FLUSH,
    ST_WAIT_OE,
    ST_TURN_ON,
    ST_SHOW,
    ST_TURN_OFF,
    ST_WAIT_HIGH
  } ffp_state_t;

endpackage

// file: rtl/ffp_flash_store.sv
// Flash word array with word program and whole-array erase
`timescale 1ns/1ps
module ffp_flash_store
  import ffp_pkg::*;
(
  input wire logic clk,
  input wire logic [FLASH_AW-1:0] rd_addr,
  output logic [DATA_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [FLASH_AW-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_overwrite,
  input wire logic erase_all
);

  logic [DATA_W-1:0] mem [2**FLASH_AW];

  // Programming only clears bits unless the page was erased first
  always_ff @(posedge clk) begin
    if (erase_all) begin
      for (int i = 0; i < 2**FLASH_AW; i++) begin
        mem[i] <= ERASED_WORD;
      end
    end else if (wr_en) begin
      if (wr_overwrite) begin
        mem[wr_addr] <= wr_data;
      end else begin
        mem[wr_addr] <= mem[wr_addr] & wr_data;
      end
    end
  end

  // Asynchronous read, sampled by the sequencer
  assign rd_data = mem[rd_addr];

endmodule

// file: rtl/ffp_port.sv
// Parallel flash programming port: handshake sequencer and command engine
`timescale 1ns/1ps
module ffp_port
  import ffp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic command_strobe_n,
  input wire logic output_enable_n,
  input wire logic [MODE_W-1:0] mode,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic ready,
  output logic data_valid_n,
  output logic [LOCK_N-1:0] lock_bits,
  output logic [FUSE_N-1:0] fuse_bits,
  output logic security_active
);

  // Write-type commands fill the page load buffer
  function automatic logic is_write_cmd(input logic [DATA_W-1:0] c);
    is_write_cmd = (c == CMD_PAGE_WRITE) || (c == CMD_PAGE_WRITE_LOCK) ||
                   (c == CMD_ERASE_THEN_WRITE) || (c == CMD_ERASE_WRITE_LOCK);
  endfunction

  // Read-type commands answer their data handshake on the bus
  function automatic logic is_read_cmd(input logic [DATA_W-1:0] c);
    is_read_cmd = (c == CMD_READ) || (c == CMD_GET_REGION_LOCK) ||
                  (c == CMD_GET_FUSE) || (c == CMD_GET_SECURITY) ||
                  (c == CMD_GET_VERSION);
  endfunction

  ffp_state_t state_q;

  // Latched handshake contents
  logic [MODE_W-1:0] mode_q;
  logic [DATA_W-1:0] word_q;
  logic [DATA_W-1:0] cmd_q;
  logic [ADDR_W-1:0] addr_q;

  // Page load buffer
  logic [DATA_W-1:0] buf_q [PAGE_WORDS];
  logic [PAGE_NUM_W-1:0] buf_page_q;
  logic dirty_q;
  logic buf_erase_q;
  logic buf_lock_q;
  logic [PAGE_AW-1:0] flush_idx_q;

  // Pin side registers
  logic ready_q;
  logic valid_n_q;
  logic oe_q;
  logic [DATA_W-1:0] dout_q;
  logic [DATA_W-1:0] rd_word_q;

  // Nonvolatile state
  logic [LOCK_N-1:0] lock_q;
  logic [FUSE_N-1:0] fuse_q;
  logic secure_q;

  // Decoded conditions
  logic [PAGE_NUM_W-1:0] cur_page;
  logic [PAGE_AW-1:0] cur_idx;
  logic [REGION_W-1:0] buf_region;
  logic page_miss;
  logic need_flush;
  logic exec_done;
  logic data_op;
  logic wr_op;
  logic flush_last;
  logic full_erase_ok;
  logic [DATA_W-1:0] st_rd_data;

  assign cur_page = addr_q[FLASH_AW-1:PAGE_AW];
  assign cur_idx = addr_q[PAGE_AW-1:0];
  assign buf_region = buf_page_q[PAGE_NUM_W-1 -: REGION_W];
  assign page_miss = dirty_q && (cur_page != buf_page_q);

  // Flush first when a command is validated or the write leaves the page
  assign need_flush = (state_q == ST_EXEC) && dirty_q &&
                      ((mode_q == MODE_CMD) ||
                       ((mode_q == MODE_DATA) && is_write_cmd(cmd_q) && page_miss));
  assign exec_done = (state_q == ST_EXEC) && !need_flush;
  assign data_op = exec_done && (mode_q == MODE_DATA) && !secure_q;
  assign wr_op = data_op && is_write_cmd(cmd_q);
  assign flush_last = (state_q == ST_FLUSH) && (&flush_idx_q);

  // Aborted while any region stays locked
  assign full_erase_ok = data_op && (cmd_q == CMD_FULL_ERASE) &&
                         (word_q == ZERO_WORD) && (lock_q == LOCK_RST);

  // Handshake sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (!command_strobe_n) begin
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          if (need_flush) begin
            state_q <= ST_FLUSH;
          end else if (data_op && is_read_cmd(cmd_q)) begin
            state_q <= ST_WAIT_OE;
          end else begin
            state_q <= ST_WAIT_HIGH;
          end
        end
        ST_FLUSH: begin
          if (flush_last) begin
            state_q <= ST_EXEC;
          end
        end
        ST_WAIT_OE: begin
          // A write-style handshake here ends the read without driving
          if (!output_enable_n) begin
            state_q <= ST_TURN_ON;
          end else if (command_strobe_n) begin
            state_q <= ST_WAIT_HIGH;
          end
        end
        ST_TURN_ON: begin
          state_q <= ST_SHOW;
        end
        ST_SHOW: begin
          if (output_enable_n) begin
            state_q <= ST_TURN_OFF;
          end
        end
        ST_TURN_OFF: begin
          state_q <= ST_WAIT_HIGH;
        end
        ST_WAIT_HIGH: begin
          if (command_strobe_n) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Mode and data captured on the falling strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      mode_q <= MODE_CMD;
      word_q <= ZERO_WORD;
    end else if ((state_q == ST_IDLE) && !command_strobe_n) begin
      mode_q <= mode;
      word_q <= data_in;
    end
  end

  // Ready drops on capture and rises once the strobe is back high
  always_ff @(posedge clk) begin
    if (rst) begin
      ready_q <= 1'b1;
    end else if ((state_q == ST_IDLE) && !command_strobe_n) begin
      ready_q <= 1'b0;
    end else if ((state_q == ST_WAIT_HIGH) && command_strobe_n) begin
      ready_q <= 1'b1;
    end
  end

  // Bus turnaround: drive before valid, release before valid rises
  always_ff @(posedge clk) begin
    if (rst) begin
      oe_q <= 1'b0;
      dout_q <= ZERO_WORD;
    end else if ((state_q == ST_WAIT_OE) && !output_enable_n) begin
      oe_q <= 1'b1;
      dout_q <= rd_word_q;
    end else if ((state_q == ST_SHOW) && output_enable_n) begin
      oe_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      valid_n_q <= 1'b1;
    end else if (state_q == ST_TURN_ON) begin
      valid_n_q <= 1'b0;
    end else if (state_q == ST_TURN_OFF) begin
      valid_n_q <= 1'b1;
    end
  end

  // Command register; a secured port takes no further command
  always_ff @(posedge clk) begin
    if (rst) begin
      cmd_q <= CMD_NONE;
    end else if (exec_done && (mode_q == MODE_CMD)) begin
      cmd_q <= secure_q ? CMD_NONE : word_q;
    end
  end

  // Address bytes load unless secured; only read and write-type data accesses step the address
  always_ff @(posedge clk) begin
    if (rst) begin
      addr_q <= ADDR_RST;
    end else if (exec_done && !secure_q) begin
      case (mode_q)
        MODE_ADDR_FIRST: addr_q[7:0] <= word_q[7:0];
        MODE_ADDR_SECOND: addr_q[15:8] <= word_q[7:0];
        MODE_ADDR_THIRD: addr_q[23:16] <= word_q[7:0];
        MODE_ADDR_LAST: addr_q[31:24] <= word_q[7:0];
        MODE_DATA: begin
          if ((cmd_q == CMD_READ) || is_write_cmd(cmd_q)) begin
            addr_q <= addr_q + 32'h0000_0001;
          end
        end
        default: begin
          addr_q <= addr_q;
        end
      endcase
    end
  end

  // Word answered by the same read handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_word_q <= ZERO_WORD;
    end else if (data_op) begin
      case (cmd_q)
        CMD_READ: rd_word_q <= st_rd_data;
        CMD_GET_REGION_LOCK: rd_word_q <= DATA_W'(lock_q);
        CMD_GET_FUSE: rd_word_q <= DATA_W'(fuse_q);
        CMD_GET_SECURITY: rd_word_q <= DATA_W'(secure_q);
        CMD_GET_VERSION: rd_word_q <= VERSION_WORD;
        default: rd_word_q <= ZERO_WORD;
      endcase
    end
  end

  // Load buffer bookkeeping; erase and lock options follow the opening command
  always_ff @(posedge clk) begin
    if (rst) begin
      dirty_q <= 1'b0;
      buf_page_q <= '0;
      buf_erase_q <= 1'b0;
      buf_lock_q <= 1'b0;
    end else if (flush_last) begin
      dirty_q <= 1'b0;
    end else if (wr_op) begin
      dirty_q <= 1'b1;
      buf_page_q <= cur_page;
      if (!dirty_q) begin
        buf_erase_q <= (cmd_q == CMD_ERASE_THEN_WRITE) ||
                       (cmd_q == CMD_ERASE_WRITE_LOCK);
        buf_lock_q <= (cmd_q == CMD_PAGE_WRITE_LOCK) ||
                      (cmd_q == CMD_ERASE_WRITE_LOCK);
      end
    end
  end

  // Buffer words; opening a page loads the addressed word and presets every other word to the erased value
  for (genvar g = 0; g < PAGE_WORDS; g++) begin : g_buf
    always_ff @(posedge clk) begin
      if (wr_op && (!dirty_q || (cur_idx == PAGE_AW'(g)))) begin
        buf_q[g] <= (cur_idx == PAGE_AW'(g)) ? word_q : ERASED_WORD;
      end
    end
  end

  // Flush walks the page one word per cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      flush_idx_q <= '0;
    end else if (state_q == ST_FLUSH) begin
      flush_idx_q <= flush_idx_q + PAGE_AW'(1);
    end
  end

  // Lock, fuse and security bits
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_q <= LOCK_RST;
      fuse_q <= FUSE_RST;
      secure_q <= 1'b0;
    end else if (flush_last && buf_lock_q) begin
      lock_q[buf_region] <= 1'b1;
    end else if (data_op) begin
      case (cmd_q)
        CMD_SET_REGION_LOCK: lock_q <= lock_q | word_q[LOCK_N-1:0];
        CMD_CLEAR_REGION_LOCK: lock_q <= lock_q & ~word_q[LOCK_N-1:0];
        CMD_SET_FUSE: fuse_q <= fuse_q | word_q[FUSE_N-1:0];
        CMD_CLEAR_FUSE: fuse_q <= fuse_q & ~word_q[FUSE_N-1:0];
        CMD_FULL_ERASE: begin
          if (full_erase_ok) begin
            lock_q <= LOCK_RST;
            fuse_q <= FUSE_RST;
          end
        end
        CMD_SET_SECURITY: begin
          if (word_q == ZERO_WORD) begin
            secure_q <= 1'b1;
          end
        end
        default: begin
          secure_q <= secure_q;
        end
      endcase
    end
  end

  // Locked regions are not reprogrammed by a flush
  ffp_flash_store u_store (
    .clk(clk),
    .rd_addr(addr_q[FLASH_AW-1:0]),
    .rd_data(st_rd_data),
    .wr_en((state_q == ST_FLUSH) && !lock_q[buf_region]),
    .wr_addr({buf_page_q, flush_idx_q}),
    .wr_data(buf_q[flush_idx_q]),
    .wr_overwrite(buf_erase_q),
    .erase_all(full_erase_ok)
  );

  // Outputs straight from flops
  assign data_out = dout_q;
  assign data_oe = oe_q;
  assign ready = ready_q;
  assign data_valid_n = valid_n_q;
  assign lock_bits = lock_q;
  assign fuse_bits = fuse_q;
  assign security_active = secure_q;

endmodule

// file: sim/ffp_port_properties.sv
// Handshake timing checks for the flash programming port
`timescale 1ns/1ps
module ffp_port_properties
  import ffp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic command_strobe_n,
  input wire logic output_enable_n,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic ready,
  input wire logic data_valid_n,
  input wire logic [LOCK_N-1:0] lock_bits,
  input wire logic [FUSE_N-1:0] fuse_bits,
  input wire logic security_active
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Idle state after every reset release
  property p_rst_idle;
    $fell(rst) |-> ready && data_valid_n && !data_oe;
  endproperty
  a_rst_idle: assert property (p_rst_idle)
    else $error("port not idle after reset");
  // A strobe seen while ready is always taken
  property p_start;
    ready && !command_strobe_n |=> !ready;
  endproperty
  a_start: assert property (p_start)
    else $error("strobe not taken");
  // Ready may only come back after the strobe is seen high
  property p_hold_low;
    !ready && !command_strobe_n |=> !ready;
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("ready rose with strobe low");
  property p_busy_drive;
    data_oe |-> !ready;
  endproperty
  a_busy_drive: assert property (p_busy_drive)
    else $error("ready high while driving");
  // Bus turns to output only after output enable low
  property p_oe_on;
    $rose(data_oe) |-> !$past(output_enable_n);
  endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus driven without output enable");
  property p_valid_fall;
    $fell(data_valid_n) |-> $past(data_oe) && data_oe;
  endproperty
  a_valid_fall: assert property (p_valid_fall)
    else $error("data valid before bus driven");
  // Word stays put while the programmer may sample it
  property p_drive_hold;
    data_oe && !output_enable_n |=> data_oe && $stable(data_out);
  endproperty
  a_drive_hold: assert property (p_drive_hold)
    else $error("bus dropped or changed early");
  property p_valid_rise;
    $fell(data_oe) |=> $rose(data_valid_n);
  endproperty
  a_valid_rise: assert property (p_valid_rise)
    else $error("data valid not raised after release");
  // Secured part changes no security, lock or fuse bit
  property p_secure;
    security_active |=> security_active && $stable(lock_bits) && $stable(fuse_bits);
  endproperty
  a_secure: assert property (p_secure)
    else $error("state changed while secured");
endmodule

bind ffp_port ffp_port_properties i_props (.clk(clk), .rst(rst),
  .command_strobe_n(command_strobe_n), .output_enable_n(output_enable_n),
  .data_out(data_out), .data_oe(data_oe), .ready(ready), .data_valid_n(data_valid_n),
  .lock_bits(lock_bits), .fuse_bits(fuse_bits), .security_active(security_active));

// file: sim/ffp_prog_model.sv
// Behavioural production programmer for the parallel handshake
`timescale 1ns/1ps
module ffp_prog_model
  import ffp_pkg::*;
(
  input wire logic clk,
  input wire logic ready,
  input wire logic data_valid_n,
  input wire logic data_oe,
  input wire logic [DATA_W-1:0] data_out,
  output logic command_strobe_n,
  output logic output_enable_n,
  output logic [MODE_W-1:0] mode,
  output wire logic [DATA_W-1:0] data_in
);
  logic drv = 1'b0;
  logic [DATA_W-1:0] val = 16'h0000;
  int n;

  // Bus wire; pulled up when nobody drives it
  assign data_in = data_oe ? data_out : (drv ? val : 16'hFFFF);

  initial begin
    command_strobe_n = 1'b1;
    output_enable_n = 1'b1;
    mode = 4'hF;
  end

  // Bounded wait so a dead port cannot hang the model
  task automatic wt(input int s, input logic v);
    for (n = 0; n < 300 && (s ? data_valid_n : ready) !== v; n++) @(posedge clk);
  endtask

  // Shared opening: present mode and data, strobe, wait for ready low
  task automatic go(input logic [3:0] m, input logic [15:0] d);
    @(posedge clk);
    wt(0, 1'b1);
    mode <= m;
    val <= d;
    drv <= 1'b1;
    command_strobe_n <= 1'b0;
    @(posedge clk);
    wt(0, 1'b0);
    drv <= 1'b0;
    mode <= 4'hF;
  endtask

  task automatic wr(input logic [3:0] m, input logic [15:0] d);
    go(m, d);
    command_strobe_n <= 1'b1;
    @(posedge clk);
    wt(0, 1'b1);
  endtask

  task automatic rd(input logic [3:0] m, input logic [15:0] d, output logic [15:0] q);
    go(m, d);
    @(posedge clk);
    output_enable_n <= 1'b0;
    @(posedge clk);
    wt(1, 1'b0);
    q = data_in;
    output_enable_n <= 1'b1;
    @(posedge clk);
    wt(1, 1'b1);
    command_strobe_n <= 1'b1;
    @(posedge clk);
    wt(0, 1'b1);
  endtask
endmodule

// file: sim/ffp_port_test.sv
// Self-checking bench for the flash programming port
`timescale 1ns/1ps
module ffp_port_test;
  import ffp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic command_strobe_n, output_enable_n, data_oe, ready, data_valid_n, security_active;
  logic [MODE_W-1:0] mode;
  logic [DATA_W-1:0] data_in, data_out, q;
  logic [LOCK_N-1:0] lock_bits;
  logic [FUSE_N-1:0] fuse_bits;
  int error_cnt = 0;
  int tests_run = 0;

  ffp_port i_dut (.clk(clk), .rst(rst), .command_strobe_n(command_strobe_n),
    .output_enable_n(output_enable_n), .mode(mode), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .ready(ready), .data_valid_n(data_valid_n),
    .lock_bits(lock_bits), .fuse_bits(fuse_bits), .security_active(security_active));
  ffp_prog_model i_prog (.clk(clk), .ready(ready), .data_valid_n(data_valid_n),
    .data_oe(data_oe), .data_out(data_out), .command_strobe_n(command_strobe_n),
    .output_enable_n(output_enable_n), .mode(mode), .data_in(data_in));

  // 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  // Command word then one data write
  task automatic two(input logic [15:0] c, input logic [15:0] d);
    i_prog.wr(MODE_CMD, c);
    i_prog.wr(MODE_DATA, d);
  endtask

  // Address bytes go first to last
  task automatic adr(input logic [31:0] a);
    for (int i = 0; i < 4; i++) i_prog.wr(MODE_ADDR_FIRST + 4'(i), {8'h00, a[8*i +: 8]});
  endtask

  task automatic rdw(input string nm, input logic [15:0] e);
    i_prog.rd(MODE_DATA, 16'h0000, q);
    chk(nm, e, q);
  endtask

  task automatic t_locks;
    chk("idle", 16'h000C, {12'h000, ready, data_valid_n, data_oe, security_active});
    two(CMD_SET_REGION_LOCK, 16'h0005);
    chk("lock set", 16'h0005, lock_bits);
    i_prog.wr(MODE_CMD, CMD_GET_REGION_LOCK);
    rdw("lock read", 16'h0005);
    two(CMD_SET_FUSE, 16'h0005);
    i_prog.wr(MODE_CMD, CMD_GET_FUSE);
    rdw("fuse read", 16'h0005);
    two(CMD_CLEAR_FUSE, 16'h0001);
    chk("fuse clr", 16'h0004, {13'h0000, fuse_bits});
    two(CMD_FULL_ERASE, 16'h0000);
    chk("locked erase", 16'h0005, lock_bits);
    chk("locked fuse", 16'h0004, {13'h0000, fuse_bits});
    two(CMD_CLEAR_REGION_LOCK, 16'h0005);
    two(CMD_FULL_ERASE, 16'h0001);
    chk("bad erase", 16'h0004, {13'h0000, fuse_bits});
    two(CMD_FULL_ERASE, 16'h0000);
    chk("erase fuse", 16'h0000, {13'h0000, fuse_bits});
  endtask

  task automatic t_rw;
    i_prog.wr(MODE_CMD, CMD_PAGE_WRITE);
    adr(32'h0000_0040);
    i_prog.wr(MODE_DATA, 16'hA5A1);
    i_prog.wr(MODE_DATA, 16'h5AA2);
    i_prog.wr(MODE_CMD, CMD_READ);
    adr(32'h0000_0040);
    rdw("rd0", 16'hA5A1);
    rdw("rd1", 16'h5AA2);
    rdw("rd2", 16'hFFFF);
    adr(32'h0000_0041);
    rdw("readdr", 16'h5AA2);
    i_prog.wr(MODE_CMD, CMD_PAGE_WRITE);
    adr(32'h0000_007F);
    i_prog.wr(MODE_DATA, 16'h1111);
    i_prog.wr(MODE_DATA, 16'h2222);
    i_prog.wr(MODE_CMD, CMD_READ);
    adr(32'h0000_007F);
    rdw("pg end", 16'h1111);
    rdw("pg next", 16'h2222);
  endtask

  task automatic t_variants;
    i_prog.wr(MODE_CMD, CMD_ERASE_THEN_WRITE);
    adr(32'h0000_0040);
    i_prog.wr(MODE_DATA, 16'h1234);
    i_prog.wr(MODE_CMD, CMD_READ);
    adr(32'h0000_0040);
    rdw("ewp word", 16'h1234);
    rdw("ewp erased", 16'hFFFF);
    i_prog.wr(MODE_CMD, CMD_PAGE_WRITE_LOCK);
    adr(32'h0000_0800);
    i_prog.wr(MODE_DATA, 16'h0F0F);
    i_prog.wr(MODE_CMD, CMD_ERASE_WRITE_LOCK);
    chk("wpl lock", 16'h0002, lock_bits);
    adr(32'h0000_1000);
    i_prog.wr(MODE_DATA, 16'h00F0);
    i_prog.wr(MODE_CMD, CMD_READ);
    adr(32'h0000_1000);
    rdw("erase_write_lock_cmd word", 16'h00F0);
    chk("erase_write_lock_cmd lock", 16'h0006, lock_bits);
  endtask

  task automatic t_misc;
    i_prog.wr(4'h9, CMD_FULL_ERASE);
    two(16'h0077, 16'h0000);
    chk("unknown", 16'h0006, lock_bits);
    chk("unknown nv", 16'h0000, {12'h000, security_active, fuse_bits});
    i_prog.wr(MODE_CMD, CMD_GET_VERSION);
    rdw("version", VERSION_WORD);
    i_prog.wr(MODE_CMD, CMD_GET_SECURITY);
    rdw("sec read", 16'h0000);
    // Version step sent as a plain write must finish without driving the bus
    two(CMD_GET_VERSION, 16'h0000);
    chk("ver wr", 16'h000C, {12'h000, ready, data_valid_n, data_oe, security_active});
    two(CMD_SET_SECURITY, 16'h0001);
    chk("sec bad", 16'h0000, {15'h0000, security_active});
    two(CMD_SET_SECURITY, 16'h0000);
    two(CMD_CLEAR_REGION_LOCK, 16'hFFFF);
    chk("secured", 16'h8006, {security_active, lock_bits[14:0]});
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk("rerst", 16'h000C, {12'h000, ready, data_valid_n, data_oe, security_active});
    // First handshake after a mid-run reset; locks come back cleared
    i_prog.wr(MODE_CMD, CMD_GET_REGION_LOCK);
    rdw("rerst lock", 16'h0000);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the roughly one thousand cycles the run needs
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_locks();
    t_rw();
    t_variants();
    t_misc();
    give_verdict();
  end
endmodule
